//--- verilog/event_counter_defs.svh
`ifndef EVENT_COUNTER_DEFS_SVH
`define EVENT_COUNTER_DEFS_SVH

`define CNT_WIDTH 16
`define CNT_MAX 16'hffff
`define CNT_MIN 16'h0000
`define CNT_RESET 16'h0000
`define CHANNEL_COUNT 5
`define LAST_CHANNEL 4
`define TWO_PHASE_FIRST 2
`define NORMAL_TWO_PHASE_LAST 3
`define X4_TWO_PHASE_FIRST 3
`define SYNC_STAGES 2

`endif

//--- verilog/event_counter_pkg.sv
package event_counter_pkg;

  typedef enum logic [1:0] {
    src_pin_type,
    src_companion_type,
    src_prev_type,
    src_next_type
  } count_source_type;

  typedef enum logic [1:0] {
    out_port_type,
    out_pulse_type,
    out_direction_type
  } out_function_type;

  typedef enum logic [1:0] {
    phase_single_type,
    phase_normal_type,
    phase_x4_type
  } phase_mode_type;

  typedef enum logic [1:0] {
    edge_falling_type,
    edge_rising_type
  } edge_select_type;

endpackage

//--- verilog/pin_sync_edge.sv
`timescale 1ns/10ps
`include "event_counter_defs.svh"

module pin_sync_edge (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic pin_in,
  output logic level,
  output logic rise,
  output logic fall
);

  logic meta_reg;
  logic sync_reg;
  logic prev_reg;

  // First stage feeds only the second stage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      prev_reg <= 1'b0;
    end else begin
      meta_reg <= pin_in;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  assign level = sync_reg;
  assign rise = sync_reg & ~prev_reg;
  assign fall = ~sync_reg & prev_reg;

endmodule

//--- verilog/event_counter_channel.sv
`timescale 1ns/10ps
`include "event_counter_defs.svh"

module event_counter_channel
  import event_counter_pkg::*;
#(
  parameter int CHANNEL_INDEX = 2,
  parameter int WIDTH = `CNT_WIDTH
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic channel_run_bit,
  input wire logic [1:0] count_source,
  input wire logic [1:0] edge_select,
  input wire logic [1:0] out_function,
  input wire logic [1:0] phase_mode,
  input wire logic direction_up_sw,
  input wire logic direction_from_pin,
  input wire logic free_run,
  input wire logic companion_wrap,
  input wire logic prev_wrap,
  input wire logic next_wrap,
  input wire logic channel_input_pin,
  input wire logic channel_output_pin_in,
  output logic channel_output_pin_out,
  output logic channel_output_pin_oe_n,
  input wire logic reload_write,
  input wire logic [WIDTH-1:0] reload_write_data,
  output logic [WIDTH-1:0] counter_value,
  output logic [WIDTH-1:0] counter_reload_register,
  output logic counting,
  output logic wrap_event,
  output logic interrupt_request
);

  initial begin
    if (WIDTH != `CNT_WIDTH) $error("Counter width must be 16");
    if (CHANNEL_INDEX < 0 || CHANNEL_INDEX > `LAST_CHANNEL) $error("Channel index out of range");
  end

  localparam logic [WIDTH-1:0] MAX_VALUE = `CNT_MAX;
  localparam logic [WIDTH-1:0] MIN_VALUE = `CNT_MIN;
  localparam bit HAS_NORMAL = (CHANNEL_INDEX >= `TWO_PHASE_FIRST) &&
                              (CHANNEL_INDEX <= `NORMAL_TWO_PHASE_LAST);
  localparam bit HAS_X4 = (CHANNEL_INDEX >= `X4_TWO_PHASE_FIRST) && (CHANNEL_INDEX <= `LAST_CHANNEL);

  logic rst_meta_reg;
  logic rst_sync_reg;
  logic rst_n;

  // Reset released through two flops; asserted asynchronously
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end
  assign rst_n = rst_sync_reg;

  logic in_level;
  logic in_rise;
  logic in_fall;
  logic op_level;
  logic op_rise;
  logic op_fall;

  pin_sync_edge in_sync (
    .clk(clk),
    .rst_n(rst_n),
    .pin_in(channel_input_pin),
    .level(in_level),
    .rise(in_rise),
    .fall(in_fall)
  );

  pin_sync_edge out_sync (
    .clk(clk),
    .rst_n(rst_n),
    .pin_in(channel_output_pin_in),
    .level(op_level),
    .rise(op_rise),
    .fall(op_fall)
  );

  // Two-phase modes fall back to single-phase on channels without them
  logic normal_mode;
  logic x4_mode;
  logic single_mode;
  assign normal_mode = HAS_NORMAL && (phase_mode == phase_normal_type);
  assign x4_mode = HAS_X4 && (phase_mode == phase_x4_type);
  assign single_mode = !normal_mode && !x4_mode;

  logic single_event;
  logic single_up;
  logic pin_edge;
  logic dir_pin_active;

  always_comb begin
    pin_edge = (edge_select == edge_rising_type) ? in_rise : in_fall;
    case (count_source)
      src_pin_type: single_event = pin_edge;
      src_companion_type: single_event = companion_wrap;
      src_prev_type: single_event = prev_wrap;
      default: single_event = next_wrap;
    endcase
  end

  // Direction pin only valid when the output pin is configured as input
  assign dir_pin_active = direction_from_pin && (out_function == out_direction_type);
  assign single_up = dir_pin_active ? op_level : direction_up_sw;

  logic normal_event;
  logic normal_up;
  assign normal_event = op_level && (in_rise || in_fall);
  assign normal_up = in_rise;

  // Up when output leads: input edge matching output level order
  logic x4_event;
  logic x4_up;
  assign x4_event = in_rise || in_fall || op_rise || op_fall;
  always_comb begin
    if (in_rise || in_fall) begin
      x4_up = (in_level == op_level);
    end else begin
      x4_up = (in_level != op_level);
    end
  end

  logic count_event;
  logic count_up;
  always_comb begin
    if (normal_mode) begin
      count_event = normal_event;
      count_up = normal_up;
    end else if (x4_mode) begin
      count_event = x4_event;
      count_up = x4_up;
    end else begin
      count_event = single_event;
      count_up = single_up;
    end
  end

  logic step;
  logic wrap;
  assign step = channel_run_bit && count_event;
  assign wrap = step && (count_up ? (counter_value == MAX_VALUE) : (counter_value == MIN_VALUE));

  // Set by first counted event after start; clears when stopped
  logic started_reg;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      started_reg <= 1'b0;
    end else if (!channel_run_bit) begin
      started_reg <= 1'b0;
    end else if (step) begin
      started_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      counter_reload_register <= `CNT_RESET;
    end else if (reload_write) begin
      counter_reload_register <= reload_write_data;
    end
  end

  // A write racing the first event lands in the counter; the event is then lost
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      counter_value <= `CNT_RESET;
    end else if (reload_write && !started_reg) begin
      counter_value <= reload_write_data;
    end else if (wrap && !free_run) begin
      counter_value <= counter_reload_register;
    end else if (step) begin
      counter_value <= count_up ? counter_value + 16'h0001 : counter_value - 16'h0001;
    end
  end

  logic pulse_reg;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pulse_reg <= 1'b0;
    end else if (!channel_run_bit) begin
      pulse_reg <= 1'b0;
    end else if (wrap) begin
      pulse_reg <= ~pulse_reg;
    end
  end

  logic irq_reg;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= wrap;
    end
  end

  // Output pin driven only as pulse output in single-phase mode; otherwise left to the port
  assign channel_output_pin_out = pulse_reg;
  assign channel_output_pin_oe_n = !((out_function == out_pulse_type) && single_mode);
  assign counting = channel_run_bit;
  assign wrap_event = irq_reg;
  assign interrupt_request = irq_reg;

  a_irq_on_wrap: assert property (@(posedge clk) disable iff (!rst_n)
    wrap |=> interrupt_request) else $error("Interrupt missed a wrap");
  a_irq_cause: assert property (@(posedge clk) disable iff (!rst_n)
    interrupt_request |-> $past(wrap)) else $error("Interrupt without wrap");
  a_reload_on_wrap: assert property (@(posedge clk) disable iff (!rst_n)
    (wrap && !free_run && !(reload_write && !started_reg)) |=> counter_value == $past(counter_reload_register))
    else $error("Reload not loaded on wrap");
  a_free_run_wrap: assert property (@(posedge clk) disable iff (!rst_n)
    (wrap && free_run && count_up && started_reg) |=> counter_value == MIN_VALUE)
    else $error("Free run did not wrap to zero");
  a_halt_holds: assert property (@(posedge clk) disable iff (!rst_n)
    (!channel_run_bit && !reload_write) |=> $stable(counter_value)) else $error("Counter moved while stopped");
  a_early_write: assert property (@(posedge clk) disable iff (!rst_n)
    (reload_write && !started_reg) |=> counter_value == $past(reload_write_data))
    else $error("Early write missed counter");
  a_late_write: assert property (@(posedge clk) disable iff (!rst_n)
    (reload_write && started_reg && !step) |=> $stable(counter_value)) else $error("Late write hit counter");
  a_pulse_low_idle: assert property (@(posedge clk) disable iff (!rst_n)
    !channel_run_bit |=> !channel_output_pin_out) else $error("Pulse output high while stopped");
  a_pulse_toggle: assert property (@(posedge clk) disable iff (!rst_n)
    (wrap && channel_run_bit) |=> channel_output_pin_out != $past(channel_output_pin_out))
    else $error("Pulse output did not invert");
  a_up_count: assert property (@(posedge clk) disable iff (!rst_n)
    (step && count_up && !wrap && started_reg) |=> counter_value == $past(counter_value) + 16'h0001)
    else $error("Up count step wrong");

endmodule

//--- tb/event_source_model.sv
`timescale 1ns/10ps
module event_source_model (
  input wire logic clk,
  output logic companion_wrap,
  output logic prev_wrap,
  output logic next_wrap,
  output logic phase_a,
  output logic phase_b
);
  initial begin
    {companion_wrap, prev_wrap, next_wrap, phase_a, phase_b} = 5'h00;
  end

  // Neighbour wrap is a single-cycle pulse
  task automatic fire(input int k);
    @(posedge clk);
    companion_wrap <= (k == 1);
    prev_wrap <= (k == 2);
    next_wrap <= (k == 3);
    @(posedge clk);
    {companion_wrap, prev_wrap, next_wrap} <= 3'h0;
    #1;
  endtask

  // Levels held long enough for the synchroniser and the count to land
  task automatic set_pins(input logic a, input logic b);
    @(posedge clk);
    phase_a <= a;
    phase_b <= b;
    repeat (5) @(posedge clk);
    #1;
  endtask
endmodule

//--- tb/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  import event_counter_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic run = 1'b0;
  logic dir_up = 1'b1;
  logic dir_pin = 1'b0;
  logic free_run = 1'b0;
  logic wr = 1'b0;
  logic [1:0] src = 2'h1;
  logic [1:0] edge_sel = 2'h1;
  logic [1:0] out_fn = 2'h1;
  logic [1:0] phase = 2'h0;
  logic [15:0] wdata = 16'h0000;
  logic comp_w, prev_w, next_w, pin_a, peer_b, pin_out, oe_n, cnting, wrap_ev, irq;
  logic [15:0] cnt, rld;
  wire logic out_wire;
  int n_fail = 0;
  int comparisons = 0;

  always #5 clk = ~clk;
  // Design drives the shared pin while its enable is low
  assign out_wire = oe_n ? peer_b : pin_out;

  event_source_model peer (.clk(clk), .companion_wrap(comp_w), .prev_wrap(prev_w), .next_wrap(next_w),
    .phase_a(pin_a), .phase_b(peer_b));

  event_counter_channel #(.CHANNEL_INDEX(2)) dut (.clk(clk), .resetn(resetn), .channel_run_bit(run),
    .count_source(src), .edge_select(edge_sel), .out_function(out_fn), .phase_mode(phase),
    .direction_up_sw(dir_up), .direction_from_pin(dir_pin), .free_run(free_run), .companion_wrap(comp_w),
    .prev_wrap(prev_w), .next_wrap(next_w), .channel_input_pin(pin_a), .channel_output_pin_in(out_wire),
    .channel_output_pin_out(pin_out), .channel_output_pin_oe_n(oe_n), .reload_write(wr),
    .reload_write_data(wdata), .counter_value(cnt), .counter_reload_register(rld), .counting(cnting),
    .wrap_event(wrap_ev), .interrupt_request(irq));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %0t %s got %h want %h", $time, msg, seen, exp);
    end
  endtask

  task automatic write_count(input logic [15:0] v);
    @(posedge clk);
    wr <= 1'b1;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask

  task automatic report_and_stop;
    if (n_fail == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    report_and_stop;
  end

  initial begin
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    repeat (4) @(posedge clk);
    #1;
    check(cnt, 16'h0000, "reset count");
    check(pin_out, 1'b0, "idle pulse low");
    check(oe_n, 1'b0, "pulse drives");
    write_count(16'hfffe);
    check(cnt, 16'hfffe, "stopped write cnt");
    check(rld, 16'hfffe, "stopped write rld");
    @(posedge clk);
    run <= 1'b1;
    write_count(16'hfff0);
    check(cnt, 16'hfff0, "early write cnt");
    check(cnting, 1'b1, "running");
    peer.fire(1);
    check(cnt, 16'hfff1, "companion up");
    // Up divide by ffff-n+1 = 16 with reload at the wrap
    for (int i = 2; i <= 16; i++) begin
      peer.fire(1);
      check(irq, (i == 16), "up wrap irq");
      check(wrap_ev, (i == 16), "up wrap event");
    end
    check(cnt, 16'hfff0, "reloaded");
    check(pin_out, 1'b1, "pulse toggled");
    write_count(16'h1234);
    check(cnt, 16'hfff0, "late write cnt");
    check(rld, 16'h1234, "late write rld");
    @(posedge clk);
    free_run <= 1'b1;
    for (int i = 1; i <= 16; i++) begin
      peer.fire(1);
      check(irq, (i == 16), "free irq");
    end
    check(cnt, 16'h0000, "free wrap");
    check(pin_out, 1'b0, "pulse back");
    @(posedge clk);
    run <= 1'b0;
    free_run <= 1'b0;
    dir_up <= 1'b0;
    src <= 2'h2;
    write_count(16'h0003);
    peer.fire(2);
    check(cnt, 16'h0003, "stopped ignores");
    @(posedge clk);
    run <= 1'b1;
    peer.fire(2);
    check(cnt, 16'h0002, "prev down");
    // Down divide by n+1 = 4
    @(posedge clk);
    src <= 2'h3;
    for (int i = 2; i <= 4; i++) begin
      peer.fire(3);
      check(irq, (i == 4), "down irq");
    end
    check(cnt, 16'h0003, "underflow reload");
    @(posedge clk);
    run <= 1'b0;
    src <= 2'h0;
    out_fn <= 2'h2;
    dir_pin <= 1'b1;
    write_count(16'h0010);
    @(posedge clk);
    run <= 1'b1;
    #1;
    check(oe_n, 1'b1, "dir pin input");
    peer.set_pins(1'b1, 1'b0);
    check(cnt, 16'h000f, "pin rise down");
    peer.set_pins(1'b0, 1'b0);
    check(cnt, 16'h000f, "fall ignored");
    peer.set_pins(1'b1, 1'b1);
    check(cnt, 16'h0010, "pin rise up");
    @(posedge clk);
    edge_sel <= 2'h0;
    peer.set_pins(1'b0, 1'b1);
    check(cnt, 16'h0011, "falling edge counts");
    peer.set_pins(1'b1, 1'b1);
    check(cnt, 16'h0011, "rise ignored");
    @(posedge clk);
    phase <= 2'h1;
    peer.set_pins(1'b0, 1'b1);
    check(cnt, 16'h0010, "two phase fall");
    peer.set_pins(1'b1, 1'b1);
    check(cnt, 16'h0011, "two phase rise");
    peer.set_pins(1'b1, 1'b0);
    peer.set_pins(1'b0, 1'b0);
    check(cnt, 16'h0011, "other low idle");
    report_and_stop;
  end
endmodule
